//--- src/nfc_mode_ctrl.sv
// Mode, transmitter and receiver control core of the NFC reader front end
//
// Behaviour
// - Power-up clears operation control register; device sits in power-down.
// - SPI and register writes work in power-down mode.
// - Bit 7 of operation control enables oscillator and regulators: ready mode.
// - In ready mode, interrupt when oscillator reports stable.
// - Receiver and transmitter enables are independent bits.
// - Wake-up bit alone enters wake-up mode with RC oscillator and timer.
// - In wake-up mode, interrupt when measurement differs from stored reference.
// - Single-driver bit set drives only one antenna output.
// - Eight segment driver; normal-level register picks carrier segments, default all.
// - Output-select bit chooses the active driver in single mode.
// - Modulation-type bit selects AM or OOK.
// - OOK stops carrier drive; fast-decay bit tristates drivers instead.
// - AM modulation switches on fewer segments than normal level.
// - Calibration command adjusts AM level towards host target.
// - Receiver on whenever receiver enable bit is 1.
// - Channel-count bit picks one or both channels; mode bit auto or manual.
// - Both channels and automatic mode: framing logic picks the channel.
// - Receive gate controls RSSI/AGC; framing processes data only while high.
// - Receive gate goes high when mask timer expires.
// - Host controls receive gate via close and open commands.
// - Slow-ramp with transmitter off collapses driver supply, then ramps on enable.
`timescale 1ns/100ps
`default_nettype none
module nfc_mode_ctrl (
	input  wire logic       MCLK,
	input  wire logic       RST_B,
	input  wire logic       CE,
	input  wire logic       SS_B,
	input  wire logic       SCLK,
	input  wire logic       MOSI,
	output logic            MISO,
	output logic            MISO_OE_B,
	output logic            IRQ,
	output logic            OSC_EN,
	output logic            REG_EN,
	input  wire logic       OSC_STABLE,
	output logic            RC_OSC_EN,
	input  wire logic       RC_TICK,
	output logic            MEAS_START,
	input  wire logic       MEAS_DONE,
	input  wire logic [7:0] MEAS_VALUE,
	output logic            RX_ENABLE,
	output logic            AM_CH_EN,
	output logic            PM_CH_EN,
	input  wire logic       AUTO_PICK_PM,
	output logic            DEMOD_SEL_PM,
	output logic            RX_GATE,
	output logic            FRAME_EN,
	input  wire logic       TX_END,
	input  wire logic       MOD,
	output logic            CAL_MEAS_REQ,
	input  wire logic       CAL_AMP_VALID,
	input  wire logic [7:0] CAL_AMP,
	output logic [7:0]      DRV_A_SEG,
	output logic            DRV_A_OE_B,
	output logic [7:0]      DRV_B_SEG,
	output logic            DRV_B_OE_B,
	output logic            SUPPLY_COLLAPSE,
	output logic            SUPPLY_SLOW_RAMP
);
	typedef enum logic [1:0] {CAL_IDLE, CAL_TRY, CAL_WAIT} cal_state_t;

	typedef struct packed {
		logic [7:0] io_cfg1;
		logic [7:0] io_cfg2;
		logic [7:0] op_ctrl;
		logic [7:0] aux;
		logic [7:0] norm_lvl;
		logic [7:0] am_lvl;
		logic [7:0] am_target;
		logic [7:0] mask_tmr;
		logic [7:0] wake_tmr;
		logic [7:0] wake_ref;
		logic [2:0] irq_flags;
		logic [1:0] osc_s;
		logic       osc_prev;
		logic [2:0] done_s;
		logic [7:0] meas1;
		logic [7:0] meas2;
		logic       rx_gate;
		logic       mask_run;
		logic [7:0] mask_cnt;
		logic [7:0] mask_pre;
		cal_state_t cal;
		logic [2:0] cal_bit;
		logic       cal_req;
		logic [7:0] drv_a;
		logic [7:0] drv_b;
		logic       oe_a_b;
		logic       oe_b_b;
	} core_state_t;

	core_state_t s;
	core_state_t next_s;
	reg_if       bus ();
	logic        wake_mode;
	logic        meas_start;
	logic [7:0]  tx_level;
	logic        tx_tri;

	// ************************************************************
	// Host interface and wake-up scheduler
	// ************************************************************
	spi_slave u_spi (
		.mclk      (MCLK),
		.rst_b     (RST_B),
		.ce        (CE),
		.ss_b      (SS_B),
		.sclk      (SCLK),
		.mosi      (MOSI),
		.miso      (MISO),
		.miso_oe_b (MISO_OE_B),
		.bus       (bus.spi)
	);

	// Wake-up mode only when the wake bit stands alone
	assign wake_mode = (s.op_ctrl == nfc_pkg::WAKE_ONLY);

	wake_timer u_wake (
		.mclk       (MCLK),
		.rst_b      (RST_B),
		.ce         (CE),
		.enable     (wake_mode),
		.period     (s.wake_tmr),
		.rc_tick    (RC_TICK),
		.meas_start (meas_start)
	);

	// ************************************************************
	// Register read mux
	// ************************************************************
	// Unmapped addresses read as zero
	always_comb
	begin
		unique case (bus.addr)
			nfc_pkg::ADDR_IO_CFG1:   bus.rdata = s.io_cfg1;
			nfc_pkg::ADDR_IO_CFG2:   bus.rdata = s.io_cfg2;
			nfc_pkg::ADDR_OP_CTRL:   bus.rdata = s.op_ctrl;
			nfc_pkg::ADDR_AUX_DEF:   bus.rdata = s.aux;
			nfc_pkg::ADDR_NORM_LVL:  bus.rdata = s.norm_lvl;
			nfc_pkg::ADDR_AM_LVL:    bus.rdata = s.am_lvl;
			nfc_pkg::ADDR_AM_TARGET: bus.rdata = s.am_target;
			nfc_pkg::ADDR_MASK_TMR:  bus.rdata = s.mask_tmr;
			nfc_pkg::ADDR_WAKE_TMR:  bus.rdata = s.wake_tmr;
			nfc_pkg::ADDR_WAKE_REF:  bus.rdata = s.wake_ref;
			nfc_pkg::ADDR_IRQ_STAT:  bus.rdata = {5'h00, s.irq_flags};
			nfc_pkg::ADDR_STATE:     bus.rdata = {3'h0, s.cal != CAL_IDLE, s.mask_run, s.rx_gate,
			                                      wake_mode, s.osc_s[1]};
			default:                 bus.rdata = 8'h00;
		endcase
	end

	// ************************************************************
	// Transmitter level selection
	// ************************************************************
	// Modulated level: AM uses the reduced set, OOK drops all segments
	assign tx_tri   = ~s.op_ctrl[nfc_pkg::OP_TX_EN_BIT]
	                  | (MOD & ~s.aux[nfc_pkg::AUX_AM_BIT] & s.aux[nfc_pkg::AUX_FAST_BIT]);
	assign tx_level = !s.op_ctrl[nfc_pkg::OP_TX_EN_BIT] ? 8'h00 : !MOD ? s.norm_lvl
	                  : s.aux[nfc_pkg::AUX_AM_BIT] ? s.am_lvl : 8'h00;

	// ************************************************************
	// Next state of the core
	// ************************************************************
	always_comb
	begin
		next_s         = s;
		next_s.cal_req = 1'b0;
		next_s.osc_s   = {s.osc_s[0], OSC_STABLE};
		next_s.osc_prev = s.osc_s[1];
		next_s.done_s  = {s.done_s[1:0], MEAS_DONE};
		next_s.meas1   = MEAS_VALUE;
		next_s.meas2   = s.meas1;

		// Register writes are honoured in every mode, power-down included
		if (bus.wr)
		begin
			unique case (bus.addr)
				nfc_pkg::ADDR_IO_CFG1:   next_s.io_cfg1   = bus.wdata;
				nfc_pkg::ADDR_IO_CFG2:   next_s.io_cfg2   = bus.wdata;
				nfc_pkg::ADDR_OP_CTRL:   next_s.op_ctrl   = bus.wdata;
				nfc_pkg::ADDR_AUX_DEF:   next_s.aux       = bus.wdata;
				nfc_pkg::ADDR_NORM_LVL:  next_s.norm_lvl  = bus.wdata;
				nfc_pkg::ADDR_AM_LVL:    next_s.am_lvl    = bus.wdata;
				nfc_pkg::ADDR_AM_TARGET: next_s.am_target = bus.wdata;
				nfc_pkg::ADDR_MASK_TMR:  next_s.mask_tmr  = bus.wdata;
				nfc_pkg::ADDR_WAKE_TMR:  next_s.wake_tmr  = bus.wdata;
				nfc_pkg::ADDR_WAKE_REF:  next_s.wake_ref  = bus.wdata;
				default:                 next_s.io_cfg1   = s.io_cfg1;
			endcase
		end

		// Status read clears the flags; a same-cycle event still wins
		if (bus.rd && bus.addr == nfc_pkg::ADDR_IRQ_STAT)
			next_s.irq_flags = 3'h0;
		if (s.op_ctrl[nfc_pkg::OP_EN_BIT] && s.osc_s[1] && !s.osc_prev)
			next_s.irq_flags[nfc_pkg::IRQ_OSC_BIT] = 1'b1;
		if (wake_mode && s.done_s[1] && !s.done_s[2] && s.meas2 != s.wake_ref)
			next_s.irq_flags[nfc_pkg::IRQ_WAKE_BIT] = 1'b1;

		// Mask timer: end of transmission closes the gate and starts counting
		if (TX_END)
		begin
			next_s.rx_gate  = 1'b0;
			next_s.mask_run = 1'b1;
			next_s.mask_cnt = s.mask_tmr;
			next_s.mask_pre = 8'h00;
		end
		else if (s.mask_run)
		begin
			if (s.mask_pre == nfc_pkg::MASK_TICK_CYCLES - 8'h01)
			begin
				next_s.mask_pre = 8'h00;
				if (s.mask_cnt == 8'h00)
				begin
					next_s.mask_run = 1'b0;
					next_s.rx_gate  = 1'b1;
				end
				else
					next_s.mask_cnt = s.mask_cnt - 8'h01;
			end
			else
				next_s.mask_pre = s.mask_pre + 8'h01;
		end

		// Direct commands override the timer in the decode cycle
		if (bus.cmd && (bus.addr == nfc_pkg::CMD_RX_CLOSE || bus.addr == nfc_pkg::CMD_RX_OPEN))
		begin
			next_s.rx_gate  = (bus.addr == nfc_pkg::CMD_RX_OPEN);
			next_s.mask_run = 1'b0;
		end

		// Successive approximation of the AM level, MSB first
		unique case (s.cal)
			CAL_IDLE:
				if (bus.cmd && bus.addr == nfc_pkg::CMD_CAL_DEPTH)
				begin
					next_s.am_lvl  = 8'h00;
					next_s.cal_bit = 3'h7;
					next_s.cal     = CAL_TRY;
				end
			CAL_TRY:
			begin
				next_s.am_lvl[s.cal_bit] = 1'b1;
				next_s.cal_req = 1'b1;
				next_s.cal     = CAL_WAIT;
			end
			CAL_WAIT:
				if (CAL_AMP_VALID)
				begin
					if (CAL_AMP > s.am_target)
						next_s.am_lvl[s.cal_bit] = 1'b0;
					if (s.cal_bit == 3'h0)
					begin
						next_s.cal = CAL_IDLE;
						next_s.irq_flags[nfc_pkg::IRQ_CAL_BIT] = 1'b1;
					end
					else
					begin
						next_s.cal_bit = s.cal_bit - 3'h1;
						next_s.cal     = CAL_TRY;
					end
				end
			default:
				next_s.cal = CAL_IDLE;
		endcase

		// Driver routing: single mode parks the unused side in tristate
		next_s.drv_a  = tx_level;
		next_s.oe_a_b = tx_tri;
		next_s.drv_b  = tx_level;
		next_s.oe_b_b = tx_tri;
		if (s.io_cfg1[nfc_pkg::CFG1_SINGLE_BIT])
		begin
			if (s.io_cfg1[nfc_pkg::CFG1_OUTSEL_BIT])
			begin
				next_s.drv_a  = 8'h00;
				next_s.oe_a_b = 1'b1;
			end
			else
			begin
				next_s.drv_b  = 8'h00;
				next_s.oe_b_b = 1'b1;
			end
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	// Power-on reset clears every control register except norm_lvl, which loads all ones
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
			s <= '{norm_lvl: nfc_pkg::RST_NORM_LVL, cal: CAL_IDLE, oe_a_b: 1'b1, oe_b_b: 1'b1,
			       default: '0};
		else if (CE)
			s <= next_s;
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Mode outputs follow the control bits directly
	assign IRQ          = |s.irq_flags;
	assign OSC_EN       = s.op_ctrl[nfc_pkg::OP_EN_BIT];
	assign REG_EN       = s.op_ctrl[nfc_pkg::OP_EN_BIT];
	assign RC_OSC_EN    = wake_mode;
	assign MEAS_START   = meas_start;
	assign RX_ENABLE    = s.op_ctrl[nfc_pkg::OP_RX_EN_BIT];
	// Single channel runs AM unless manual select asks for PM
	assign AM_CH_EN     = RX_ENABLE & (s.op_ctrl[nfc_pkg::OP_RX_CHN_BIT] | ~s.aux[nfc_pkg::AUX_MANSEL_BIT]);
	assign PM_CH_EN     = RX_ENABLE & (s.op_ctrl[nfc_pkg::OP_RX_CHN_BIT] | s.aux[nfc_pkg::AUX_MANSEL_BIT]);
	assign DEMOD_SEL_PM = (s.op_ctrl[nfc_pkg::OP_RX_CHN_BIT] & ~s.op_ctrl[nfc_pkg::OP_RX_MAN_BIT])
	                      ? AUTO_PICK_PM : s.aux[nfc_pkg::AUX_MANSEL_BIT];
	assign RX_GATE      = s.rx_gate;
	assign FRAME_EN     = s.rx_gate & RX_ENABLE;
	assign CAL_MEAS_REQ = s.cal_req;
	assign DRV_A_SEG    = s.drv_a;
	assign DRV_A_OE_B   = s.oe_a_b;
	assign DRV_B_SEG    = s.drv_b;
	assign DRV_B_OE_B   = s.oe_b_b;
	// Supply collapses while waiting off, ramps slowly once enabled
	assign SUPPLY_COLLAPSE  = s.io_cfg2[nfc_pkg::CFG2_SLOW_BIT] & ~s.op_ctrl[nfc_pkg::OP_TX_EN_BIT];
	assign SUPPLY_SLOW_RAMP = s.io_cfg2[nfc_pkg::CFG2_SLOW_BIT] & s.op_ctrl[nfc_pkg::OP_TX_EN_BIT];
endmodule : nfc_mode_ctrl
`default_nettype wire

//--- src/nfc_pkg.sv
// Shared constants for the NFC front end mode and control block
package nfc_pkg;
	// ************************************************************
	// Register addresses (6-bit SPI address space)
	// ************************************************************
	localparam logic [5:0] ADDR_IO_CFG1   = 6'h00;
	localparam logic [5:0] ADDR_IO_CFG2   = 6'h01;
	localparam logic [5:0] ADDR_OP_CTRL   = 6'h02;
	localparam logic [5:0] ADDR_AUX_DEF   = 6'h03;
	localparam logic [5:0] ADDR_NORM_LVL  = 6'h04;
	localparam logic [5:0] ADDR_AM_LVL    = 6'h05;
	localparam logic [5:0] ADDR_AM_TARGET = 6'h06;
	localparam logic [5:0] ADDR_MASK_TMR  = 6'h07;
	localparam logic [5:0] ADDR_WAKE_TMR  = 6'h08;
	localparam logic [5:0] ADDR_WAKE_REF  = 6'h09;
	localparam logic [5:0] ADDR_IRQ_STAT  = 6'h0a;
	localparam logic [5:0] ADDR_STATE     = 6'h0b;
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int OP_EN_BIT       = 7;
	localparam int OP_RX_EN_BIT    = 6;
	localparam int OP_RX_CHN_BIT   = 5;
	localparam int OP_RX_MAN_BIT   = 4;
	localparam int OP_TX_EN_BIT    = 3;
	localparam int OP_WU_BIT       = 2;
	localparam int CFG1_SINGLE_BIT = 7;
	localparam int CFG1_OUTSEL_BIT = 6;
	localparam int CFG2_SLOW_BIT   = 7;
	localparam int AUX_AM_BIT      = 5;
	localparam int AUX_FAST_BIT    = 4;
	localparam int AUX_MANSEL_BIT  = 0;
	localparam int IRQ_OSC_BIT     = 0;
	localparam int IRQ_WAKE_BIT    = 1;
	localparam int IRQ_CAL_BIT     = 2;
	// ************************************************************
	// Reset values and the wake-only control value
	// ************************************************************
	localparam logic [7:0] RST_ZERO     = 8'h00;
	localparam logic [7:0] RST_NORM_LVL = 8'hff;
	localparam logic [7:0] WAKE_ONLY    = 8'h04;
	// ************************************************************
	// SPI header modes and direct commands
	// ************************************************************
	localparam logic [1:0] MODE_WR  = 2'h0;
	localparam logic [1:0] MODE_RD  = 2'h1;
	localparam logic [1:0] MODE_CMD = 2'h3;
	localparam logic [5:0] CMD_RX_CLOSE  = 6'h10;
	localparam logic [5:0] CMD_RX_OPEN   = 6'h11;
	localparam logic [5:0] CMD_CAL_DEPTH = 6'h12;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 5;
	localparam int MASK_TICK_NS  = 1000;
	localparam logic [7:0] MASK_TICK_CYCLES = 8'(MASK_TICK_NS / CLK_PERIOD_NS);
endpackage : nfc_pkg

//--- src/reg_if.sv
// Register access carrier between the SPI slave and the control core
`timescale 1ns/100ps
`default_nettype none
interface reg_if;
	logic       wr;
	logic       rd;
	logic       cmd;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport spi  (output wr, output rd, output cmd, output addr, output wdata, input rdata);
	modport core (input wr, input rd, input cmd, input addr, input wdata, output rdata);
endinterface : reg_if
`default_nettype wire

//--- src/spi_slave.sv
// SPI mode 0 slave, oversampled by the core clock
`timescale 1ns/100ps
`default_nettype none
module spi_slave (
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic ce,
	input  wire logic ss_b,
	input  wire logic sclk,
	input  wire logic mosi,
	output logic      miso,
	output logic      miso_oe_b,
	reg_if.spi        bus
);
	typedef struct packed {
		logic [1:0] ss_s;
		logic [2:0] sck_s;
		logic [1:0] mosi_s;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] tx;
		logic [1:0] mode;
		logic [5:0] addr;
		logic       wr;
		logic       rd;
		logic       cmd;
	} spi_state_t;

	spi_state_t s;
	spi_state_t next_s;
	logic       rise;
	logic       fall;

	// ************************************************************
	// Frame decoding: header byte, then one data byte
	// ************************************************************
	// Edges come from the second and third flops, never the first
	assign rise = s.sck_s[1] & ~s.sck_s[2];
	assign fall = ~s.sck_s[1] & s.sck_s[2];

	// Next state of the shifter
	always_comb
	begin
		next_s        = s;
		next_s.wr     = 1'b0;
		next_s.rd     = 1'b0;
		next_s.cmd    = 1'b0;
		next_s.ss_s   = {s.ss_s[0], ss_b};
		next_s.sck_s  = {s.sck_s[1:0], sclk};
		next_s.mosi_s = {s.mosi_s[0], mosi};
		if (s.ss_s[1])
		begin
			next_s.cnt = 4'h0;
			next_s.tx  = 8'h00;
		end
		else if (rise)
		begin
			next_s.sh  = {s.sh[6:0], s.mosi_s[1]};
			next_s.cnt = s.cnt + 4'h1;
			if (s.cnt == 4'h7)
			begin
				next_s.mode = s.sh[6:5];
				next_s.addr = {s.sh[4:0], s.mosi_s[1]};
				next_s.cmd  = (s.sh[6:5] == nfc_pkg::MODE_CMD);
				next_s.rd   = (s.sh[6:5] == nfc_pkg::MODE_RD);
			end
			if (s.cnt == 4'hf && s.mode == nfc_pkg::MODE_WR)
				next_s.wr = 1'b1;
		end
		else if (fall && s.cnt != 4'h8)
			next_s.tx = {s.tx[6:0], 1'b0}; // First read bit must survive the header's last fall
		if (s.rd)
			next_s.tx = bus.rdata;
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			s <= '{ss_s: 2'h3, default: '0};
		else if (ce)
			s <= next_s;
	end

	assign miso      = s.tx[7];
	assign miso_oe_b = s.ss_s[1];
	assign bus.wr    = s.wr;
	assign bus.rd    = s.rd;
	assign bus.cmd   = s.cmd;
	assign bus.addr  = s.addr;
	assign bus.wdata = s.sh;
endmodule : spi_slave
`default_nettype wire

//--- src/wake_timer.sv
// Wake-up scheduler counting low power RC oscillator ticks
`timescale 1ns/100ps
`default_nettype none
module wake_timer (
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic       ce,
	input  wire logic       enable,
	input  wire logic [7:0] period,
	input  wire logic       rc_tick,
	output logic            meas_start
);
	typedef struct packed {
		logic [2:0] tick_s;
		logic [7:0] cnt;
		logic       start;
	} wake_state_t;

	wake_state_t s;
	wake_state_t next_s;

	// Count tick edges; a period of zero behaves as one tick
	always_comb
	begin
		next_s        = s;
		next_s.start  = 1'b0;
		next_s.tick_s = {s.tick_s[1:0], rc_tick};
		if (!enable)
			next_s.cnt = 8'h00;
		else if (s.tick_s[1] & ~s.tick_s[2])
		begin
			if (s.cnt >= period)
			begin
				next_s.cnt   = 8'h00;
				next_s.start = 1'b1;
			end
			else
				next_s.cnt = s.cnt + 8'h01;
		end
	end

	// State register
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

	assign meas_start = s.start;
endmodule : wake_timer
`default_nettype wire

//--- sim/nfc_mode_ctrl_chk.sv
// Port-level assertions for the mode control core
`timescale 1ns/100ps
`default_nettype none
module nfc_mode_ctrl_chk (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic CE,
	input wire logic OSC_STABLE,
	input wire logic TX_END,
	input wire logic IRQ,
	input wire logic OSC_EN,
	input wire logic REG_EN,
	input wire logic RC_OSC_EN,
	input wire logic MEAS_START,
	input wire logic RX_ENABLE,
	input wire logic AM_CH_EN,
	input wire logic PM_CH_EN,
	input wire logic RX_GATE,
	input wire logic FRAME_EN,
	input wire logic CAL_MEAS_REQ,
	input wire logic DRV_A_OE_B,
	input wire logic SUPPLY_COLLAPSE,
	input wire logic SUPPLY_SLOW_RAMP
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	// ****
	// Relations
	// ****
	a_reset_clears: assert property ($rose(RST_B) |-> !OSC_EN && !IRQ && !RX_GATE && DRV_A_OE_B)
		else $error("outputs not cleared by reset");
	a_osc_regs: assert property (OSC_EN == REG_EN)
		else $error("oscillator and regulator enables differ");
	a_osc_irq: assert property (OSC_EN && $rose(OSC_STABLE) |-> ##[1:8] IRQ)
		else $error("no interrupt after oscillator stable");
	a_wake_alone: assert property (RC_OSC_EN |-> !OSC_EN && !RX_ENABLE)
		else $error("wake mode with other bits set");
	a_meas_pulse: assert property (MEAS_START |=> !MEAS_START)
		else $error("measurement start longer than one cycle");
	a_rx_chan: assert property (RX_ENABLE |-> AM_CH_EN || PM_CH_EN)
		else $error("receiver on without a channel");
	a_frame_gate: assert property (FRAME_EN == (RX_GATE && RX_ENABLE))
		else $error("framing enable not tied to gate");
	a_mask_hold: assert property (TX_END && CE |=> !RX_GATE [*8])
		else $error("gate open during mask time");
	a_cal_pulse: assert property (CAL_MEAS_REQ |=> !CAL_MEAS_REQ)
		else $error("calibration request too long");
	a_ramp_excl: assert property (!(SUPPLY_COLLAPSE && SUPPLY_SLOW_RAMP))
		else $error("supply collapse and ramp together");
	// Main scenarios reached
	c_irq: cover property ($rose(IRQ));
	c_gate: cover property ($rose(RX_GATE));
	c_meas: cover property (MEAS_START);
	c_cal: cover property (CAL_MEAS_REQ);
endmodule : nfc_mode_ctrl_chk
`default_nettype wire

//--- sim/spi_host_model.sv
// SPI master standing in for the host controller
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
	output logic       SS_B,
	output logic       SCLK,
	output logic       MOSI,
	input  wire logic  MISO,
	output logic [7:0] RDATA,
	output logic       RVALID
);
	// Link idles deselected with the clock standing low
	initial
	begin
		SS_B = 1'b1;
		SCLK = 1'b0;
		MOSI = 1'b1;
		RDATA = 8'h00;
		RVALID = 1'b0;
	end
	// One whole frame, MSB first, mode 0; 64 ns bit time
	task automatic frame(input logic [7:0] hdr, input logic [7:0] dat, input bit two);
		logic [15:0] sh;
		sh = {hdr, dat};
		SS_B = 1'b0;
		for (int i = 0; i < (two ? 16 : 8); i++)
		begin
			MOSI = sh[15];
			#32 SCLK = 1'b1;
			RDATA = {RDATA[6:0], MISO};
			sh = sh << 1;
			#32 SCLK = 1'b0;
		end
		#32 SS_B = 1'b1;
		MOSI = ~MOSI; // Released line shows no stale level
		RVALID = (hdr[7:6] == 2'h1);
		#64 RVALID = 1'b0;
	endtask : frame
endmodule : spi_host_model
`default_nettype wire

//--- sim/nfc_mode_ctrl_tb.sv
// Self-checking bench for the mode control core
`timescale 1ns/100ps
`default_nettype none
module nfc_mode_ctrl_tb;
	logic mclk = 1'b0;
	logic rst_b, ce, ss_b, sclk, mosi, miso, miso_oe_b, irq, osc_en, reg_en, osc_stable, rc_osc_en, rc_tick;
	logic meas_start, meas_done, rx_enable, am_ch_en, pm_ch_en, auto_pick_pm, demod_sel_pm, rx_gate, frame_en;
	logic tx_end, mod, cal_meas_req, cal_amp_valid, drv_a_oe_b, drv_b_oe_b, supply_collapse, supply_slow_ramp;
	logic rvalid;
	logic [7:0] meas_value, cal_amp, drv_a_seg, drv_b_seg, rdata, tgt, nl, acc, trial, meas;
	logic [7:0] expq[$];
	logic [7:0] auxv[3] = '{8'h20, 8'h00, 8'h10};
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	int n_try;
	nfc_mode_ctrl dut (.MCLK(mclk), .RST_B(rst_b), .CE(ce), .SS_B(ss_b), .SCLK(sclk), .MOSI(mosi), .MISO(miso),
		.MISO_OE_B(miso_oe_b), .IRQ(irq), .OSC_EN(osc_en), .REG_EN(reg_en), .OSC_STABLE(osc_stable),
		.RC_OSC_EN(rc_osc_en), .RC_TICK(rc_tick), .MEAS_START(meas_start), .MEAS_DONE(meas_done),
		.MEAS_VALUE(meas_value), .RX_ENABLE(rx_enable), .AM_CH_EN(am_ch_en), .PM_CH_EN(pm_ch_en),
		.AUTO_PICK_PM(auto_pick_pm), .DEMOD_SEL_PM(demod_sel_pm), .RX_GATE(rx_gate), .FRAME_EN(frame_en),
		.TX_END(tx_end), .MOD(mod), .CAL_MEAS_REQ(cal_meas_req), .CAL_AMP_VALID(cal_amp_valid),
		.CAL_AMP(cal_amp), .DRV_A_SEG(drv_a_seg), .DRV_A_OE_B(drv_a_oe_b), .DRV_B_SEG(drv_b_seg),
		.DRV_B_OE_B(drv_b_oe_b), .SUPPLY_COLLAPSE(supply_collapse), .SUPPLY_SLOW_RAMP(supply_slow_ramp));
	spi_host_model host (.SS_B(ss_b), .SCLK(sclk), .MOSI(mosi), .MISO(miso), .RDATA(rdata), .RVALID(rvalid));
	// ****
	// Clock, timeout and responders
	// ****
	always #2.5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			miscompares++;
			conclude();
		end
	end
	// RC oscillator runs free; it only counts in wake mode
	always
	begin
		repeat (8) @(negedge mclk);
		rc_tick = ~rc_tick;
	end
	// Presence sensor answers each request with the current value
	always @(posedge mclk)
		if (meas_start === 1'b1)
		begin
			@(negedge mclk);
			meas_value = meas;
			@(negedge mclk);
			meas_done = 1'b1;
			repeat (4) @(negedge mclk);
			meas_done = 1'b0;
		end
	// Amplitude follows the trial level so the search must land on the target
	always @(posedge mclk)
		if (cal_meas_req === 1'b1)
		begin
			trial = acc | (8'h80 >> n_try);
			n_try++;
			if (trial <= tgt)
				acc = trial;
			@(negedge mclk);
			cal_amp = trial;
			cal_amp_valid = 1'b1;
			@(negedge mclk);
			cal_amp_valid = 1'b0;
		end
	// Read data matched against the oldest expectation
	always @(posedge rvalid)
		chk("readback", expq.pop_front(), rdata);
	// ****
	// Tasks
	// ****
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		host.frame({nfc_pkg::MODE_WR, a}, d, 1'b1);
		repeat (4) @(negedge mclk);
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		expq.push_back(e);
		host.frame({nfc_pkg::MODE_RD, a}, 8'h00, 1'b1);
		repeat (4) @(negedge mclk);
	endtask : rd
	task automatic cmd(input logic [5:0] c);
		host.frame({nfc_pkg::MODE_CMD, c}, 8'h00, 1'b0);
		repeat (4) @(negedge mclk);
	endtask : cmd
	task automatic await_irq;
		for (int n = 0; n < 400 && irq !== 1'b1; n++)
			@(negedge mclk);
		chk("irq", 8'h01, {7'h0, irq});
	endtask : await_irq
	task automatic conclude;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	// ****
	// Main sequence
	// ****
	initial
	begin
		{rst_b, meas_done, meas_value, auto_pick_pm, tx_end, mod, cal_amp_valid, cal_amp} = '0;
		{rc_tick, osc_stable, n_try, acc, meas} = '0;
		ce = 1'b1;
		tgt = 8'($urandom(32'h0718));
		repeat (6) @(negedge mclk);
		rst_b = 1'b1;
		repeat (3) @(negedge mclk);
		chk("oe_rst", 8'h03, {6'h0, drv_a_oe_b, miso_oe_b});
		rd(nfc_pkg::ADDR_OP_CTRL, nfc_pkg::RST_ZERO);
		rd(nfc_pkg::ADDR_NORM_LVL, nfc_pkg::RST_NORM_LVL);
		rd(6'h3f, 8'h00);
		tgt = 8'($urandom);
		wr(nfc_pkg::ADDR_AM_TARGET, tgt);
		rd(nfc_pkg::ADDR_AM_TARGET, tgt);
		$display("power-down test done");
		wr(nfc_pkg::ADDR_OP_CTRL, 8'h80);
		chk("osc_en", 8'h01, {7'h0, osc_en});
		osc_stable = 1'b1;
		await_irq();
		rd(nfc_pkg::ADDR_IRQ_STAT, 8'h01);
		cmd(nfc_pkg::CMD_CAL_DEPTH);
		await_irq();
		rd(nfc_pkg::ADDR_IRQ_STAT, 8'h04);
		rd(nfc_pkg::ADDR_AM_LVL, tgt);
		$display("ready and calibration test done");
		nl = 8'($urandom);
		wr(nfc_pkg::ADDR_NORM_LVL, nl);
		wr(nfc_pkg::ADDR_OP_CTRL, 8'h88);
		chk("seg_a", nl, drv_a_seg);
		chk("seg_b", nl, drv_b_seg);
		mod = 1'b1;
		foreach (auxv[i])
		begin
			wr(nfc_pkg::ADDR_AUX_DEF, auxv[i]);
			chk("mod_seg", auxv[i][5] ? tgt : 8'h00, drv_a_seg);
			chk("mod_oe", {7'h0, auxv[i][4]}, {7'h0, drv_a_oe_b});
		end
		mod = 1'b0;
		for (int s = 0; s < 2; s++)
		begin
			wr(nfc_pkg::ADDR_IO_CFG1, {1'b1, s[0], 6'h0});
			chk("seg_on", nl, s ? drv_b_seg : drv_a_seg);
			chk("oe_off", 8'h01, {7'h0, s ? drv_a_oe_b : drv_b_oe_b});
		end
		wr(nfc_pkg::ADDR_IO_CFG1, 8'h00);
		wr(nfc_pkg::ADDR_OP_CTRL, 8'h80);
		wr(nfc_pkg::ADDR_IO_CFG2, 8'h80);
		repeat (100) @(negedge mclk); // hold shortened
		chk("collapse", 8'h01, {7'h0, supply_collapse});
		wr(nfc_pkg::ADDR_OP_CTRL, 8'h88);
		chk("ramp", 8'h01, {7'h0, supply_slow_ramp});
		wr(nfc_pkg::ADDR_IO_CFG2, 8'h00);
		$display("transmitter test done");
		wr(nfc_pkg::ADDR_OP_CTRL, 8'hc0);
		chk("rx_only", 8'h03, {6'h0, rx_enable, drv_a_oe_b});
		chk("one_chan", 8'h01, {7'h0, am_ch_en ^ pm_ch_en});
		wr(nfc_pkg::ADDR_OP_CTRL, 8'he0);
		for (int p = 0; p < 2; p++)
		begin
			auto_pick_pm = p[0];
			@(negedge mclk);
			chk("auto", {5'h0, 2'h3, p[0]}, {5'h0, am_ch_en, pm_ch_en, demod_sel_pm});
		end
		auto_pick_pm = 1'b0;
		wr(nfc_pkg::ADDR_AUX_DEF, 8'h01);
		wr(nfc_pkg::ADDR_OP_CTRL, 8'hf0);
		chk("manual", 8'h01, {7'h0, demod_sel_pm});
		wr(nfc_pkg::ADDR_MASK_TMR, 8'h01);
		for (int k = 0; k < 2; k++)
		begin
			tx_end = 1'b1;
			@(negedge mclk);
			tx_end = 1'b0;
			if (k == 1)
				cmd(nfc_pkg::CMD_RX_CLOSE);
			repeat (390) @(negedge mclk);
			chk("gate_mask", 8'h00, {7'h0, rx_gate});
			repeat (20) @(negedge mclk);
			chk("gate_end", {7'h0, k == 0}, {7'h0, rx_gate});
			cmd(k ? nfc_pkg::CMD_RX_OPEN : nfc_pkg::CMD_RX_CLOSE);
			chk("gate_cmd", {7'h0, k == 1}, {7'h0, rx_gate});
		end
		$display("receiver test done");
		wr(nfc_pkg::ADDR_OP_CTRL, 8'h00);
		wr(nfc_pkg::ADDR_WAKE_REF, 8'h33);
		wr(nfc_pkg::ADDR_WAKE_TMR, 8'h01);
		meas = 8'h33;
		wr(nfc_pkg::ADDR_OP_CTRL, nfc_pkg::WAKE_ONLY);
		repeat (200) @(negedge mclk);
		chk("wake_same", 8'h02, {6'h0, rc_osc_en, irq});
		meas = 8'h34;
		await_irq();
		wr(nfc_pkg::ADDR_OP_CTRL, 8'h00);
		rd(nfc_pkg::ADDR_IRQ_STAT, 8'h02);
		$display("wake test done");
		conclude();
	end
endmodule : nfc_mode_ctrl_tb
bind nfc_mode_ctrl nfc_mode_ctrl_chk chk (.MCLK(MCLK), .RST_B(RST_B), .CE(CE), .OSC_STABLE(OSC_STABLE),
	.TX_END(TX_END), .IRQ(IRQ), .OSC_EN(OSC_EN), .REG_EN(REG_EN), .RC_OSC_EN(RC_OSC_EN), .MEAS_START(MEAS_START),
	.RX_ENABLE(RX_ENABLE), .AM_CH_EN(AM_CH_EN), .PM_CH_EN(PM_CH_EN), .RX_GATE(RX_GATE), .FRAME_EN(FRAME_EN),
	.CAL_MEAS_REQ(CAL_MEAS_REQ), .DRV_A_OE_B(DRV_A_OE_B), .SUPPLY_COLLAPSE(SUPPLY_COLLAPSE),
	.SUPPLY_SLOW_RAMP(SUPPLY_SLOW_RAMP));
`default_nettype wire
